// file: rtl/mbiu_consts.svh
// Constants for the multiplexed bus interface unit
`ifndef MBIU_CONSTS_SVH
`define MBIU_CONSTS_SVH
// Reset configuration bit positions on the low-order address pins
`define MBIU_CFG_BOOT16_BIT 3
`define MBIU_CFG_BOOT8_BIT 2
`define MBIU_CFG_RSVD_HI_BIT 1
`define MBIU_CFG_EXT_HOLD_BIT 0
`define MBIU_CFG_RST_VAL 4'h0
// Bus field positions and sizes
`define MBIU_HI_ADDR_LSB 4
`define MBIU_STROBE_W 4
`define MBIU_STROBES_OFF 4'hF
`define MBIU_QUAD_BYTES 5'h10
`define MBIU_CLK_PERIOD_NS 40
`endif

// file: rtl/mbiu_pkg.sv
// Types for the multiplexed bus interface unit
package mbiu_pkg;
   typedef enum logic [1:0] {
      MBIU_PW_32 = 2'h0,
      MBIU_PW_16 = 2'h1,
      MBIU_PW_8 = 2'h2
   } mbiu_port_w_e;
   typedef enum logic [1:0] {
      MBIU_SZ_BYTE = 2'h0,
      MBIU_SZ_HALF = 2'h1,
      MBIU_SZ_WORD = 2'h2
   } mbiu_size_e;
   typedef enum logic [3:0] {
      MBIU_ST_IDLE = 4'h1,
      MBIU_ST_ADDR = 4'h2,
      MBIU_ST_HOLD = 4'h4,
      MBIU_ST_DATA = 4'h8
   } mbiu_state_e;
endpackage

// file: rtl/mbiu_top.sv
// Multiplexed address/data bus interface unit of the processor
//
// Overview of operation
// - Address phase drives transfer address bits 31:4 onto the bus.
// - Address phase puts four lane strobes on bus bits 3:0, high one lane 3.
// - Lane strobes only meaningful for 32-bit ports; otherwise held inactive.
// - With the inhibit control set, strobes stay inactive on reads.
// - Data phase uses the whole bus on 32-bit ports; narrow ports use low, or big-endian high, lanes.
// - Writes drive store data from the write buffer entry.
// - Reads return one datum or four words into the read buffer.
// - Active lanes follow datum size, port width and byte order.
// - Low address is 4 bits; valid bits depend on port width.
// - Low address always shows the datum currently transferred.
// - Writes and single reads start at target, step when datum exceeds port.
// - Quad reads count low address from zero by port width.
// - Low address pins sampled during reset as four configuration options.
// - Diagnostic pin is time multiplexed for miss and instruction/data.
// - Data phase diagnostic high for instruction, low for data.
// - Address phase diagnostic high when read caused by cache miss.
`timescale 1ns/10ps
`default_nettype none
`include "mbiu_consts.svh"

module mbiu_top #(
   parameter int DATA_W = 32,
   parameter int LO_ADDR_W = 4
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Request from the core side
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic req_quad_i,
   input wire logic [1:0] req_size_i,
   input wire logic [31:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   input wire logic req_instr_i,
   input wire logic req_miss_i,
   // Configuration from the system control coprocessor
   input wire logic [1:0] port_width_i,
   input wire logic big_endian_i,
   input wire logic read_strobe_inhibit_i,
   // Read buffer side
   output logic [DATA_W-1:0] rd_data_o,
   output logic rd_data_valid_o,
   output logic xfer_done_o,
   // Multiplexed bus pins
   input wire logic [DATA_W-1:0] ad_i,
   output logic [DATA_W-1:0] ad_o,
   output logic ad_oe_o,
   input wire logic [LO_ADDR_W-1:0] low_addr_i,
   output logic [LO_ADDR_W-1:0] low_addr_o,
   output logic low_addr_oe_o,
   output logic ale_o,
   output logic rd_n_o,
   output logic wr_n_o,
   input wire logic ack_i,
   output logic diag_o,
   // Reset configuration options
   output logic boot_rom_16bit_option_o,
   output logic boot_rom_8bit_option_o,
   output logic reserved_high_option_o,
   output logic extended_address_hold_option_o
);

   initial
   begin
      if (DATA_W != 32 || LO_ADDR_W != 4)
      begin
         $error("mbiu_top serves only a 32-bit bus with 4 low address bits");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Bytes per beat for the port width
   function automatic logic [4:0] step_of(input logic [1:0] pw);
      logic [4:0] s;
      s = 5'h01;
      if (pw == mbiu_pkg::MBIU_PW_32)
      begin
         s = 5'h04;
      end
      else if (pw == mbiu_pkg::MBIU_PW_16)
      begin
         s = 5'h02;
      end
      return s;
   endfunction

   // Bytes in the datum
   function automatic logic [4:0] size_bytes(input logic [1:0] sz);
      logic [4:0] b;
      b = 5'h04;
      if (sz == mbiu_pkg::MBIU_SZ_BYTE)
      begin
         b = 5'h01;
      end
      else if (sz == mbiu_pkg::MBIU_SZ_HALF)
      begin
         b = 5'h02;
      end
      return b;
   endfunction

   // Bus lane holding byte offset o of a word
   function automatic logic [1:0] lane_of(input logic [1:0] o,
                                          input logic big);
      return big ? 2'(2'h3 - o) : o;
   endfunction

   // Bus image of the current beat of a write
   function automatic logic [31:0] unpack(input logic [31:0] w,
                                          input logic [1:0] o,
                                          input logic [1:0] pw,
                                          input logic big);
      logic [31:0] r;
      logic [1:0] ln;
      r = w;
      ln = lane_of(o, big);
      if (pw == mbiu_pkg::MBIU_PW_16)
      begin
         r = 32'h0000_0000;
         if (big)
         begin
            r[31:16] = ln[1] ? w[31:16] : w[15:0];
         end
         else
         begin
            r[15:0] = ln[1] ? w[31:16] : w[15:0];
         end
      end
      else if (pw != mbiu_pkg::MBIU_PW_32)
      begin
         r = 32'h0000_0000;
         if (big)
         begin
            r[31:24] = w[8*ln +: 8];
         end
         else
         begin
            r[7:0] = w[8*ln +: 8];
         end
      end
      return r;
   endfunction

   // Merge one read beat into the word being packed
   function automatic logic [31:0] pack(input logic [31:0] acc,
                                        input logic [31:0] d,
                                        input logic [1:0] o,
                                        input logic [1:0] pw,
                                        input logic big);
      logic [31:0] r;
      logic [1:0] ln;
      r = d;
      ln = lane_of(o, big);
      if (pw == mbiu_pkg::MBIU_PW_16)
      begin
         r = acc;
         if (ln[1])
         begin
            r[31:16] = big ? d[31:16] : d[15:0];
         end
         else
         begin
            r[15:0] = big ? d[31:16] : d[15:0];
         end
      end
      else if (pw != mbiu_pkg::MBIU_PW_32)
      begin
         r = acc;
         r[8*ln +: 8] = big ? d[31:24] : d[7:0];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Transaction state

   mbiu_pkg::mbiu_state_e state_ff;
   mbiu_pkg::mbiu_state_e nxt_state;
   logic write_ff;
   logic quad_ff;
   logic instr_ff;
   logic miss_ff;
   logic [1:0] pw_ff;
   logic big_ff;
   logic [31:0] addr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] strobes_n_ff;
   logic [3:0] lo_ff;
   logic [4:0] rem_ff;
   logic [31:0] rbuf_ff;
   logic [3:0] cfg_ff;
   logic [4:0] step;
   logic last_beat;
   logic word_end;
   logic take;
   logic beat;
   logic [3:0] lane_mask;
   logic [3:0] nxt_strobes_n;

   assign take = req_valid_i && req_ready_o;
   assign beat = (state_ff == mbiu_pkg::MBIU_ST_DATA) && ack_i;
   assign step = step_of(pw_ff);
   assign last_beat = rem_ff <= step;
   assign word_end = last_beat || (5'(lo_ff) + step) % 5'h04 == 5'h00;
   assign req_ready_o = (state_ff == mbiu_pkg::MBIU_ST_IDLE) && !srst_i;

   // Byte lanes chosen by size, offset and byte order
   always_comb
   begin
      lane_mask = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (i >= req_addr_i[1:0] &&
             i < 5'(req_addr_i[1:0]) + size_bytes(req_size_i))
         begin
            lane_mask[lane_of(2'(i), big_endian_i)] = 1'b1;
         end
      end
      if (req_quad_i)
      begin
         lane_mask = 4'hF;
      end
      nxt_strobes_n = ~lane_mask;
      if (port_width_i != mbiu_pkg::MBIU_PW_32 ||
          (!req_write_i && read_strobe_inhibit_i))
      begin
         nxt_strobes_n = `MBIU_STROBES_OFF;
      end
   end

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         mbiu_pkg::MBIU_ST_IDLE:
         begin
            if (take)
            begin
               nxt_state = mbiu_pkg::MBIU_ST_ADDR;
            end
         end
         mbiu_pkg::MBIU_ST_ADDR:
         begin
            nxt_state = cfg_ff[`MBIU_CFG_EXT_HOLD_BIT] ?
                        mbiu_pkg::MBIU_ST_HOLD : mbiu_pkg::MBIU_ST_DATA;
         end
         mbiu_pkg::MBIU_ST_HOLD:
         begin
            nxt_state = mbiu_pkg::MBIU_ST_DATA;
         end
         mbiu_pkg::MBIU_ST_DATA:
         begin
            if (beat && last_beat)
            begin
               nxt_state = mbiu_pkg::MBIU_ST_IDLE;
            end
         end
         default:
         begin
            nxt_state = mbiu_pkg::MBIU_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         state_ff <= mbiu_pkg::MBIU_ST_IDLE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Request capture
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         write_ff <= 1'b0;
         quad_ff <= 1'b0;
         instr_ff <= 1'b0;
         miss_ff <= 1'b0;
         pw_ff <= mbiu_pkg::MBIU_PW_32;
         big_ff <= 1'b0;
         addr_ff <= 32'h0000_0000;
         wdata_ff <= 32'h0000_0000;
         strobes_n_ff <= `MBIU_STROBES_OFF;
      end
      else if (take)
      begin
         write_ff <= req_write_i;
         quad_ff <= req_quad_i && !req_write_i;
         instr_ff <= req_instr_i;
         miss_ff <= req_miss_i;
         pw_ff <= port_width_i;
         big_ff <= big_endian_i;
         addr_ff <= req_addr_i;
         wdata_ff <= req_wdata_i;
         strobes_n_ff <= nxt_strobes_n;
      end
   end

   // Low address counter and remaining byte count
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         lo_ff <= 4'h0;
         rem_ff <= 5'h00;
      end
      else if (take)
      begin
         if (req_quad_i && !req_write_i)
         begin
            lo_ff <= 4'h0;
            rem_ff <= `MBIU_QUAD_BYTES;
         end
         else
         begin
            lo_ff <= req_addr_i[3:0];
            rem_ff <= size_bytes(req_size_i);
         end
      end
      else if (beat && !last_beat)
      begin
         lo_ff <= lo_ff + step[3:0];
         rem_ff <= rem_ff - step;
      end
   end

   // Read packing into the read buffer
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         rbuf_ff <= 32'h0000_0000;
         rd_data_o <= 32'h0000_0000;
         rd_data_valid_o <= 1'b0;
      end
      else
      begin
         rd_data_valid_o <= 1'b0;
         if (beat && !write_ff)
         begin
            rbuf_ff <= pack(rbuf_ff, ad_i, lo_ff[1:0], pw_ff, big_ff);
            if (word_end)
            begin
               rd_data_o <= pack(rbuf_ff, ad_i, lo_ff[1:0], pw_ff, big_ff);
               rd_data_valid_o <= 1'b1;
            end
         end
      end
   end

   // Reset configuration sampled from the low address pins
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         cfg_ff <= low_addr_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive

   always_comb
   begin
      ad_o = 32'h0000_0000;
      ad_oe_o = 1'b0;
      ale_o = 1'b0;
      diag_o = 1'b0;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      unique case (state_ff)
         mbiu_pkg::MBIU_ST_IDLE:
         begin
            ad_oe_o = 1'b0;
         end
         mbiu_pkg::MBIU_ST_ADDR, mbiu_pkg::MBIU_ST_HOLD:
         begin
            ad_o = {addr_ff[31:`MBIU_HI_ADDR_LSB], strobes_n_ff};
            ad_oe_o = 1'b1;
            ale_o = state_ff == mbiu_pkg::MBIU_ST_ADDR;
            diag_o = miss_ff && !write_ff;
         end
         mbiu_pkg::MBIU_ST_DATA:
         begin
            ad_o = write_ff ? unpack(wdata_ff, lo_ff[1:0], pw_ff, big_ff)
                            : 32'h0000_0000;
            ad_oe_o = write_ff;
            diag_o = instr_ff && !write_ff;
            rd_n_o = write_ff;
            wr_n_o = !write_ff;
         end
         default:
         begin
            ad_oe_o = 1'b0;
         end
      endcase
   end

   assign low_addr_o = lo_ff;
   assign low_addr_oe_o = !srst_i;
   assign xfer_done_o = beat && last_beat;
   assign boot_rom_16bit_option_o = cfg_ff[`MBIU_CFG_BOOT16_BIT];
   assign boot_rom_8bit_option_o = cfg_ff[`MBIU_CFG_BOOT8_BIT];
   assign reserved_high_option_o = cfg_ff[`MBIU_CFG_RSVD_HI_BIT];
   assign extended_address_hold_option_o = cfg_ff[`MBIU_CFG_EXT_HOLD_BIT];

endmodule
`default_nettype wire

// file: dv/mbiu_top_properties.sv
// Port-level checks for the bus interface unit
`timescale 1ns/10ps
`default_nettype none
module mbiu_chk (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire logic req_write_i,
   input wire logic req_quad_i,
   input wire logic [31:0] req_addr_i,
   input wire logic req_instr_i,
   input wire logic req_miss_i,
   input wire logic [1:0] port_width_i,
   input wire logic read_strobe_inhibit_i,
   input wire logic [31:0] ad_o,
   input wire logic ad_oe_o,
   input wire logic [3:0] low_addr_o,
   input wire logic ale_o,
   input wire logic rd_n_o,
   input wire logic wr_n_o,
   input wire logic ack_i,
   input wire logic diag_o,
   input wire logic xfer_done_o
);
   logic instr_ff;
   logic quad_ff;
   logic [3:0] lo_ff;
   logic [3:0] step_ff;
   wire logic beat = !rd_n_o || !wr_n_o;
   always_ff @(posedge ref_clk_i)
   begin
      if (req_valid_i && req_ready_o)
      begin
         instr_ff <= req_instr_i;
         quad_ff <= req_quad_i && !req_write_i;
         lo_ff <= req_addr_i[3:0];
         step_ff <= (port_width_i == 2'h0) ? 4'h4
            : ((port_width_i == 2'h1) ? 4'h2 : 4'h1);
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_take;
      req_valid_i && req_ready_o;
   endsequence
   sequence s_rd_take;
      s_take ##0 !req_write_i;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   AST_HI_ADDR: assert property (s_take |=> ale_o
      && ad_o[31:4] == $past(req_addr_i[31:4])) else $error("high address");
   AST_ALE_CAUSE: assert property (ale_o |-> $past(req_ready_o))
      else $error("latch strobe without request");
   AST_LANES_NARROW: assert property (
      s_take ##0 port_width_i != 2'h0 |=> ad_o[3:0] == 4'hF)
      else $error("strobes on narrow port");
   AST_RD_INHIBIT: assert property (
      s_rd_take ##0 read_strobe_inhibit_i |=> ad_o[3:0] == 4'hF)
      else $error("strobes on inhibited read");
   AST_RD_MISS: assert property (
      s_rd_take |=> diag_o == $past(req_miss_i)) else $error("miss flag");
   AST_ID_PHASE: assert property (!rd_n_o |-> diag_o == instr_ff)
      else $error("fetch kind flag");
   AST_LO_START: assert property ($rose(beat)
      |-> low_addr_o == (quad_ff ? 4'h0 : lo_ff)) else $error("first address");
   AST_LO_STEP: assert property (
      beat && ack_i && !xfer_done_o |=> low_addr_o == $past(low_addr_o)
      + step_ff) else $error("address step");
   AST_DONE: assert property (xfer_done_o |-> ack_i ##1 req_ready_o)
      else $error("completion");
   AST_RD_RELEASE: assert property (!rd_n_o |-> !ad_oe_o)
      else $error("bus driven during read data");
   AST_WR_DRIVE: assert property ((ale_o || !wr_n_o) |-> ad_oe_o)
      else $error("bus not driven");
endmodule
bind mbiu_top mbiu_chk mbiu_chk_inst (.ref_clk_i(ref_clk_i),
   .srst_i(srst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
   .req_write_i(req_write_i), .req_quad_i(req_quad_i),
   .req_addr_i(req_addr_i), .req_instr_i(req_instr_i),
   .req_miss_i(req_miss_i), .port_width_i(port_width_i),
   .read_strobe_inhibit_i(read_strobe_inhibit_i), .ad_o(ad_o),
   .ad_oe_o(ad_oe_o),
   .low_addr_o(low_addr_o), .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
   .ack_i(ack_i), .diag_o(diag_o), .xfer_done_o(xfer_done_o));
`default_nettype wire

// file: dv/mbiu_mem_model.sv
// External memory with address latches
`timescale 1ns/10ps
`default_nettype none
module mbiu_mem_model (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [3:0] cfg_i,
   input wire logic [1:0] wait_i,
   input wire logic [31:0] bus_i,
   input wire logic ale_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [3:0] lo_i,
   output logic [31:0] rdata_o,
   output logic [3:0] cfg_pins_o,
   output logic ack_o,
   output logic [31:0] latch_o,
   output logic [31:0] wdata_o
);
   logic [31:0] latch_ff = 32'h0;
   logic [31:0] last_ff = 32'h0;
   logic [1:0] cnt_ff = 2'h0;
   wire logic beat = !rd_n_i || !wr_n_i;
   assign ack_o = beat && cnt_ff == wait_i;
   // Released bus shows the inverse of the last datum
   assign rdata_o = rd_n_i ? ~last_ff : {latch_ff[31:4], lo_i};
   assign cfg_pins_o = srst_i ? cfg_i : ~cfg_i;
   assign latch_o = latch_ff;
   always_ff @(posedge ref_clk_i)
   begin
      if (ale_i)
         latch_ff <= bus_i;
      if (!rd_n_i)
         last_ff <= rdata_o;
      cnt_ff <= (ack_o || !beat) ? 2'h0 : cnt_ff + 2'h1;
      if (!wr_n_i && ack_o)
         wdata_o <= bus_i;
   end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Testbench for the bus interface unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic req_valid_i = 1'b0;
   logic req_write_i = 1'b0;
   logic req_quad_i = 1'b0;
   logic req_im = 1'b0;
   logic inh = 1'b0;
   logic big = 1'b0;
   logic [1:0] req_size_i = 2'h2;
   logic [1:0] port_width_i = 2'h0;
   logic [31:0] req_addr_i = 32'h0;
   logic [3:0] cfg = 4'hA;
   logic [1:0] wait_n = 2'h0;
   wire logic req_ready_o, rd_data_valid_o, xfer_done_o, ale_o, rd_n_o;
   wire logic wr_n_o, ack_i, diag_o, ad_oe_o;
   wire logic [31:0] ad_i, ad_o, rd_data_o, latch, wdata;
   wire logic [3:0] low_addr_i, low_addr_o, opt;
   int fail_count = 0;
   int n_checks = 0;
   int beats;
   logic [31:0] words[$];
   always #20 ref_clk_i = ~ref_clk_i;
   mbiu_top mbiu_top_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_write_i(req_write_i), .req_quad_i(req_quad_i),
      .req_size_i(req_size_i), .req_addr_i(req_addr_i),
      .req_wdata_i(~req_addr_i), .req_instr_i(req_im),
      .req_miss_i(req_im ^ inh),
      .port_width_i(port_width_i), .big_endian_i(big),
      .read_strobe_inhibit_i(inh), .rd_data_o(rd_data_o),
      .rd_data_valid_o(rd_data_valid_o), .xfer_done_o(xfer_done_o),
      .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .low_addr_i(low_addr_i),
      .low_addr_o(low_addr_o), .low_addr_oe_o(), .ale_o(ale_o),
      .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .ack_i(ack_i), .diag_o(diag_o),
      .boot_rom_16bit_option_o(opt[3]), .boot_rom_8bit_option_o(opt[2]),
      .reserved_high_option_o(opt[1]),
      .extended_address_hold_option_o(opt[0]));
   mbiu_mem_model mbiu_mem_model_inst (.ref_clk_i(ref_clk_i),
      .srst_i(srst_i), .cfg_i(cfg), .wait_i(wait_n), .bus_i(ad_o),
      .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .lo_i(low_addr_o),
      .rdata_o(ad_i), .cfg_pins_o(low_addr_i), .ack_o(ack_i),
      .latch_o(latch), .wdata_o(wdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic fail(input string m);
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic check(input logic [31:0] got, exp, input string m);
      n_checks++;
      if (got !== exp)
         fail($sformatf("%s got %h exp %h", m, got, exp));
   endtask
   task automatic xfer(input logic w, q, im, h, input logic [1:0] sz, pw,
         input logic [31:0] a);
      logic seen;
      @(posedge ref_clk_i);
      req_valid_i <= 1'b1;
      req_write_i <= w;
      req_quad_i <= q;
      req_im <= im;
      inh <= h;
      req_size_i <= sz;
      port_width_i <= pw;
      req_addr_i <= a;
      @(posedge ref_clk_i);
      req_valid_i <= 1'b0;
      beats = 0;
      words.delete();
      seen = 1'b0;
      for (int i = 0; i < 200; i++)
      begin
         @(negedge ref_clk_i);
         if (rd_data_valid_o === 1'b1)
            words.push_back(rd_data_o);
         if (seen)
            break;
         beats += int'(ack_i === 1'b1);
         seen = (xfer_done_o === 1'b1);
      end
      if (!seen)
         fail("no completion");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_cfg(input logic [3:0] c);
      @(posedge ref_clk_i);
      srst_i <= 1'b1;
      cfg <= c;
      repeat (5) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(negedge ref_clk_i);
      check({28'h0, opt}, {28'h0, c}, "options");
   endtask
   task automatic t_write;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 2'h2, 2'h0, 32'h89AB_CDE4);
      check(wdata, 32'h7654_321B, "store data");
      check(latch, 32'h89AB_CDE0, "address word");
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 32'h89AB_CDE5);
      check(latch, 32'h89AB_CDED, "byte lane");
      @(posedge ref_clk_i);
      big <= 1'b1;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 32'h89AB_CDE5);
      check(latch, 32'h89AB_CDEB, "big byte lane");
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 2'h2, 32'h1234_5670);
      check(words[0], 32'h1212_1212, "big pack 8");
      @(posedge ref_clk_i);
      big <= 1'b0;
      for (int p = 1; p < 3; p++)
      begin
         xfer(1'b1, 1'b0, 1'b0, 1'b0, 2'h2, p[1:0], 32'h89AB_CDE4);
         check(beats, 32'h1 << p, "beats");
      end
   endtask
   task automatic t_read;
      for (int h = 0; h < 2; h++)
      begin
         xfer(1'b0, 1'b0, h[0], h[0], 2'h2, 2'h0, 32'h0246_8ACC);
         check(words[0], 32'h0246_8ACC, "read");
         check(latch, {28'h02468AC, h[0] ? 4'hF : 4'h0}, "rd lanes");
      end
   endtask
   task automatic t_quad;
      @(posedge ref_clk_i);
      wait_n <= 2'h2;
      xfer(1'b0, 1'b1, 1'b1, 1'b0, 2'h2, 2'h0, 32'h1357_9BD8);
      for (int k = 0; k < 4; k++)
         check(words[k], {28'h13579BD, 4'(4 * k)}, "quad");
      @(posedge ref_clk_i);
      wait_n <= 2'h0;
   endtask
   task automatic t_pack;
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 2'h1, 32'h1234_5670);
      check(words[0], 32'h5672_5670, "pack 16");
      xfer(1'b0, 1'b0, 1'b1, 1'b0, 2'h2, 2'h2, 32'h1234_5670);
      check(words[0], 32'h7372_7170, "pack 8");
   endtask
   initial
   begin
      t_cfg(4'hA);
      t_write;
      t_read;
      t_quad;
      t_pack;
      t_cfg(4'h1);
      t_read;
      tally_and_finish;
   end
   initial
   begin
      repeat (3000) @(posedge ref_clk_i);
      fail("watchdog");
      tally_and_finish;
   end
endmodule
`default_nettype wire
